// ### src/gpio4_pkg.sv
package gpio4_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_HIGH_CFG  = 8'h0c;
    localparam logic [7:0] ADDR_LOW_CFG   = 8'h0d;
    localparam logic [7:0] ADDR_HIGH_TRIG = 8'h0e;
    localparam logic [7:0] ADDR_LOW_TRIG  = 8'h0f;
    localparam logic [7:0] ADDR_PENDING   = 8'h10;
    // ------------------------------------------------------------
    // reset values and fields
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE     = 8'h00;
    localparam int         PIN4_CFG_LSB   = 0;
    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] CFG_INPUT      = 2'h0;
    localparam logic [1:0] CFG_INPUT_PU   = 2'h1;
    localparam logic [1:0] CFG_ANALOG     = 2'h2;
    localparam logic [1:0] CFG_OUTPUT     = 2'h3;
    localparam logic [1:0] TRIG_OFF       = 2'h0;
    localparam logic [1:0] TRIG_FALL      = 2'h1;
    localparam logic [1:0] TRIG_RISE      = 2'h2;
    localparam logic [1:0] TRIG_BOTH      = 2'h3;
endpackage

// ### src/port4_pin_config_ext_irq.sv
`timescale 1ns/1ps
module port4_pin_config_ext_irq (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // pins
    input  wire logic [7:0] pin_in,
    input  wire logic [4:0] pin_out_val,
    output logic      [4:0] pin_out,
    output logic      [4:0] pin_oe,
    output logic      [4:0] pin_pullup,
    output logic      [4:0] analog_sel,
    // interrupt controller
    output logic      [7:0] ext_irq
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] cfg_of(input logic [7:0] low, input logic [7:0] high,
                                          input int n);
        logic [1:0] f;
        f = 2'h0;
        if (n < 4) begin
            f = low[2*n +: 2];
        end else begin
            f = high[gpio4_pkg::PIN4_CFG_LSB +: 2];
        end
        return f;
    endfunction

    function automatic logic edge_hit(input logic [1:0] trig, input logic rise, input logic fall);
        logic h;
        h = 1'b0;
        case (trig)
            gpio4_pkg::TRIG_OFF:  h = 1'b0;
            gpio4_pkg::TRIG_FALL: h = fall;
            gpio4_pkg::TRIG_RISE: h = rise;
            gpio4_pkg::TRIG_BOTH: h = rise | fall;
            default:              h = 1'b0;
        endcase
        return h;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] high_cfg_reg, high_cfg_next;
    logic [7:0] low_cfg_reg, low_cfg_next;
    logic [7:0] high_trig_reg, high_trig_next;
    logic [7:0] low_trig_reg, low_trig_next;
    logic [7:0] pend_reg, pend_next;
    logic [7:0] sync1_reg, sync1_next;
    logic [7:0] sync2_reg, sync2_next;
    logic [7:0] last_reg, last_next;
    logic [7:0] rdata_next;
    logic [4:0] out_next, oe_next, pu_next, an_next;
    logic [7:0] hit;
    logic [15:0] trig_all;

    assign trig_all = {high_trig_reg, low_trig_reg};

    // ------------------------------------------------------------
    // pin synchroniser and edge history
    // ------------------------------------------------------------
    // only the second stage feeds edge detection, so a metastable first
    // stage never reaches the pending bits; costs two cycles of latency
    always_comb begin
        sync1_next = pin_in;
        sync2_next = sync1_reg;
        last_next  = sync2_reg;
    end

    // a pin idling high shows a rising edge just after reset; harmless,
    // since every trigger field resets to disabled
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
            last_reg  <= 8'h00;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            last_reg  <= last_next;
        end
    end

    // ------------------------------------------------------------
    // registers, pending bits and pin controls
    // ------------------------------------------------------------

    always_comb begin
        logic [1:0] f;
        f              = 2'h0;
        high_cfg_next  = high_cfg_reg;
        low_cfg_next   = low_cfg_reg;
        high_trig_next = high_trig_reg;
        low_trig_next  = low_trig_reg;
        for (int n = 0; n < 8; n++) begin
            // synchronised level only, two stages ahead
            hit[n] = edge_hit(trig_all[2*n +: 2], sync2_reg[n] & ~last_reg[n],
                              ~sync2_reg[n] & last_reg[n]);
        end
        // writing zero clears, writing one keeps; a new edge wins over the clear
        pend_next = pend_reg;
        if (reg_wr && reg_addr == gpio4_pkg::ADDR_PENDING) begin
            pend_next = pend_reg & reg_wdata;
        end
        pend_next = pend_next | hit;
        if (reg_wr) begin
            case (reg_addr)
                gpio4_pkg::ADDR_HIGH_CFG:  high_cfg_next  = reg_wdata;
                gpio4_pkg::ADDR_LOW_CFG:   low_cfg_next   = reg_wdata;
                gpio4_pkg::ADDR_HIGH_TRIG: high_trig_next = reg_wdata;
                gpio4_pkg::ADDR_LOW_TRIG:  low_trig_next  = reg_wdata;
                default: ;
            endcase
        end
        case (reg_addr)
            gpio4_pkg::ADDR_HIGH_CFG:  rdata_next = high_cfg_reg;
            gpio4_pkg::ADDR_LOW_CFG:   rdata_next = low_cfg_reg;
            gpio4_pkg::ADDR_HIGH_TRIG: rdata_next = high_trig_reg;
            gpio4_pkg::ADDR_LOW_TRIG:  rdata_next = low_trig_reg;
            gpio4_pkg::ADDR_PENDING:   rdata_next = pend_reg;
            default:                   rdata_next = 8'h00;
        endcase
        if (!reg_rd) begin
            rdata_next = reg_rdata;
        end
        // controls follow the register value being written, so a new role
        // shows on the pins at the same edge as the register itself
        for (int n = 0; n < 5; n++) begin
            f = cfg_of(low_cfg_next, high_cfg_next, n);
            oe_next[n]  = (f == gpio4_pkg::CFG_OUTPUT);
            pu_next[n]  = (f == gpio4_pkg::CFG_INPUT_PU);
            an_next[n]  = (f == gpio4_pkg::CFG_ANALOG);
            out_next[n] = (f == gpio4_pkg::CFG_OUTPUT) & pin_out_val[n];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            high_cfg_reg  <= gpio4_pkg::RESET_BYTE;
            low_cfg_reg   <= gpio4_pkg::RESET_BYTE;
            high_trig_reg <= gpio4_pkg::RESET_BYTE;
            low_trig_reg  <= gpio4_pkg::RESET_BYTE;
            pend_reg      <= gpio4_pkg::RESET_BYTE;
            reg_rdata     <= 8'h00;
            pin_out       <= 5'h00;
            pin_oe        <= 5'h00;
            pin_pullup    <= 5'h00;
            analog_sel    <= 5'h00;
            ext_irq       <= 8'h00;
        end else begin
            high_cfg_reg  <= high_cfg_next;
            low_cfg_reg   <= low_cfg_next;
            high_trig_reg <= high_trig_next;
            low_trig_reg  <= low_trig_next;
            pend_reg      <= pend_next;
            reg_rdata     <= rdata_next;
            pin_out       <= out_next;
            pin_oe        <= oe_next;
            pin_pullup    <= pu_next;
            analog_sel    <= an_next;
            ext_irq       <= pend_next;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_irq_follows_pend: assert property (ext_irq == pend_reg)
        else $error("request output differs from pending bits");
    a_rise_sets_pend: assert property (
        (trig_all[5:4] == gpio4_pkg::TRIG_RISE) && sync2_reg[2] && !last_reg[2]
        |=> pend_reg[2])
        else $error("rising edge did not set pending bit 2");
    a_fall_sets_pend: assert property (
        (trig_all[3:2] == gpio4_pkg::TRIG_FALL) && !sync2_reg[1] && last_reg[1]
        |=> pend_reg[1])
        else $error("falling edge did not set pending bit 1");
    a_off_no_set: assert property (
        (trig_all[1:0] == gpio4_pkg::TRIG_OFF) && !pend_reg[0] |=> !pend_reg[0])
        else $error("disabled pin raised pending");
    a_zero_clears: assert property (
        reg_wr && reg_addr == gpio4_pkg::ADDR_PENDING && !reg_wdata[3] && !hit[3]
        |=> !pend_reg[3])
        else $error("write zero did not clear pending");
    a_one_keeps: assert property (
        reg_wr && reg_addr == gpio4_pkg::ADDR_PENDING && reg_wdata[3] && pend_reg[3]
        |=> pend_reg[3])
        else $error("write one changed pending");
    a_pend_read: assert property (
        reg_rd && reg_addr == gpio4_pkg::ADDR_PENDING |=> reg_rdata == $past(pend_reg))
        else $error("pending read mismatch");
    a_rdata_holds: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_unmapped_read: assert property (
        reg_rd && reg_addr > gpio4_pkg::ADDR_PENDING |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");
    a_cfg_write: assert property (
        reg_wr && reg_addr == gpio4_pkg::ADDR_LOW_CFG |=> low_cfg_reg == $past(reg_wdata))
        else $error("low config write lost");
    a_cfg_output: assert property (pin_oe[4] == (high_cfg_reg[1:0] == gpio4_pkg::CFG_OUTPUT))
        else $error("pin 4 output enable wrong");
    a_cfg_analog: assert property (analog_sel[2] == (low_cfg_reg[5:4] == gpio4_pkg::CFG_ANALOG))
        else $error("pin 2 analog select wrong");
    a_cfg_pullup: assert property (pin_pullup[1] == (low_cfg_reg[3:2] == gpio4_pkg::CFG_INPUT_PU))
        else $error("pin 1 pull-up wrong");
    a_out_gated: assert property (
        pin_out[3] == (pin_oe[3] && $past(pin_out_val[3])))
        else $error("pin 3 output value wrong");
    a_fall_both: assert property (
        (trig_all[15:14] == gpio4_pkg::TRIG_BOTH) && !sync2_reg[7] && last_reg[7]
        |=> ext_irq[7])
        else $error("falling edge missed on pin 7");
    // main scenarios: edges set bits, software clears them, pins change role
    c_pend_set: cover property (!pend_reg[2] ##1 pend_reg[2]);
    c_pend_fall: cover property (!pend_reg[1] ##1 pend_reg[1]);
    c_pend_clear: cover property (pend_reg[7] ##1 !pend_reg[7]);
    c_analog: cover property (analog_sel[2]);
    c_drive_out: cover property (pin_oe[4] && pin_out[4]);
endmodule

// ### tb/pin_model.sv
`timescale 1ns/1ps
module pin_model (
    // design side
    input  wire logic [4:0] pin_oe,
    input  wire logic [4:0] pin_out,
    // far side
    input  wire logic [7:0] drive,
    output logic      [7:0] pin_in
);
    // a pin in push-pull mode reads back what the device drives, so the
    // external driver loses the pad there
    always_comb begin
        pin_in = drive;
        for (int i = 0; i < 5; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end
        end
    end
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic       ref_clk     = 1'b0;
    logic       rst_n       = 1'b0;
    logic       reg_wr      = 1'b0;
    logic       reg_rd      = 1'b0;
    logic [7:0] reg_addr    = 8'h00;
    logic [7:0] reg_wdata   = 8'h00;
    logic [7:0] drive       = 8'h00;
    logic [4:0] pin_out_val = 5'h1f;
    logic [7:0] reg_rdata, pin_in, ext_irq;
    logic [4:0] pin_out, pin_oe, pin_pullup, analog_sel;
    int         miscompares = 0;
    int         total_checks = 0;

    port4_pin_config_ext_irq dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out_val(pin_out_val), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .analog_sel(analog_sel), .ext_irq(ext_irq));
    pin_model u_pins (.pin_oe(pin_oe), .pin_out(pin_out), .drive(drive), .pin_in(pin_in));

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // ----
    // access tasks
    // ----
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask
    // read data is registered at the read edge and checked right after it
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk(reg_rdata, exp);
    endtask
    task automatic edges(input logic [7:0] lvl);
        @(negedge ref_clk);
        drive = lvl;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ----
    // tests
    // ----
    initial begin
        #40000;
        miscompares++;
        print_verdict();
    end
    initial begin
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        wr(8'h11, 8'hff);
        for (int a = 12; a < 18; a++) rdc(8'(a), 8'h00);
        $display("test reset done");
        wr(gpio4_pkg::ADDR_LOW_CFG, 8'he4);
        wr(gpio4_pkg::ADDR_HIGH_CFG, 8'h03);
        @(negedge ref_clk);
        chk({3'h0, pin_oe}, 8'h18);
        chk({3'h0, pin_pullup}, 8'h02);
        chk({3'h0, analog_sel}, 8'h04);
        chk({3'h0, pin_out}, 8'h18);
        pin_out_val = 5'h08;
        @(negedge ref_clk);
        chk({3'h0, pin_out}, 8'h08);
        pin_out_val = 5'h1f;
        rdc(gpio4_pkg::ADDR_LOW_CFG, 8'he4);
        wr(gpio4_pkg::ADDR_LOW_CFG, 8'h00);
        wr(gpio4_pkg::ADDR_HIGH_CFG, 8'h00);
        $display("test config done");
        wr(gpio4_pkg::ADDR_LOW_TRIG, 8'he4);
        wr(gpio4_pkg::ADDR_HIGH_TRIG, 8'he4);
        rdc(gpio4_pkg::ADDR_PENDING, 8'h00);
        edges(8'hff);
        rdc(gpio4_pkg::ADDR_PENDING, 8'hcc);
        chk(ext_irq, 8'hcc);
        wr(gpio4_pkg::ADDR_PENDING, 8'h00);
        repeat (2) @(negedge ref_clk);
        chk(ext_irq, 8'h00);
        edges(8'h00);
        rdc(gpio4_pkg::ADDR_PENDING, 8'haa);
        wr(gpio4_pkg::ADDR_PENDING, 8'hff);
        rdc(gpio4_pkg::ADDR_PENDING, 8'haa);
        wr(gpio4_pkg::ADDR_PENDING, 8'h2a);
        rdc(gpio4_pkg::ADDR_PENDING, 8'h2a);
        $display("test trigger done");
        @(negedge ref_clk);
        rst_n = 1'b0;
        @(negedge ref_clk);
        rst_n = 1'b1;
        rdc(gpio4_pkg::ADDR_PENDING, 8'h00);
        rdc(gpio4_pkg::ADDR_LOW_TRIG, 8'h00);
        $display("test rerun reset done");
        print_verdict();
    end
endmodule
